// ===== dv/pmc_core_model.sv
/*
  Partner model of the core side: issues the power-save instruction with its
  operand and runs the low-power RC oscillator.
  Assumes clk_i is the device system clock and rst_i its synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module pmc_core_model #(
  parameter int RC_HALF = 25
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Towards the device
  output logic      power_save_instruction_o,
  output logic      power_save_sleep_o,
  output logic      low_power_rc_clock_o
);
  int rc_cnt_q;

  initial begin
    power_save_instruction_o = 1'h0;
    power_save_sleep_o       = 1'h0;
  end

  // ****************************************************************
  // Free-running RC oscillator, kept alive for the watchdog
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    rc_cnt_q <= (rst_i || rc_cnt_q == RC_HALF - 1) ? 0 : rc_cnt_q + 1;
    if (rst_i) begin
      low_power_rc_clock_o <= 1'h0;
    end else if (rc_cnt_q == RC_HALF - 1) begin
      low_power_rc_clock_o <= !low_power_rc_clock_o;
    end
  end

  // One instruction pulse; the operand stays put until the next call
  task automatic exec_power_save_instruction(input logic sleep);
    @(posedge clk_i);
    power_save_instruction_o <= 1'h1;
    power_save_sleep_o       <= sleep;
    @(posedge clk_i);
    power_save_instruction_o <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== dv/test_power_mode_controller.sv
/*
  Self-checking bench for the power-mode controller: registers, Doze,
  Idle, the four Sleep variants, lockout and the reset pin.
  Assumes pmc_pkg and pmc_top are compiled first, with the core model.
*/
`timescale 1ns/10ps
`default_nettype none
module test_power_mode_controller
  import pmc_pkg::*;
();
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic        clk_i, rst_i, pin_n, fuse, irq, wdt_en, wdt_to, fail_safe_clock_monitor_en;
  logic        pwr, pwr_sleep, rc, cpu_en, sys_en, per_en, fail_safe_clock_monitor_act, rc_en;
  logic        wdt_clr, ret_en, bg_en, resume, avs_read, avs_write, avs_waitrequest;
  logic        retention_enable_bit, regulator_standby_bit, eff;
  logic [2:0]  clk_src, src_o;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, flags;
  logic [1:0]  mode_tbl [5] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h3};
  int          error_cnt, checks_done, n, lat;

  assign flags = {24'h0, resume, cpu_en, sys_en, per_en, fail_safe_clock_monitor_act, rc_en, bg_en, ret_en};

  pmc_core_model #(.RC_HALF(25)) pmc_core_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .power_save_instruction_o(pwr),
    .power_save_sleep_o(pwr_sleep), .low_power_rc_clock_o(rc));

  pmc_top #(.LOW_POWER_RC_CLOCK_WAKE(4)) pmc_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .external_reset_pin_n_i(pin_n),
    .low_power_rc_clock_i(rc), .retention_config_fuse_i(fuse),
    .power_save_instruction_i(pwr), .power_save_sleep_i(pwr_sleep),
    .irq_pending_i(irq), .watchdog_timer_en_i(wdt_en), .watchdog_timer_timeout_i(wdt_to),
    .fail_safe_clock_monitor_en_i(fail_safe_clock_monitor_en), .clk_src_i(clk_src),
    .cpu_clk_en_o(cpu_en), .sys_clk_en_o(sys_en), .periph_clk_en_o(per_en),
    .fail_safe_clock_monitor_active_o(fail_safe_clock_monitor_act), .low_power_rc_clock_en_o(rc_en),
    .watchdog_timer_clear_o(wdt_clr), .retention_reg_en_o(ret_en), .bandgap_en_o(bg_en),
    .clk_src_o(src_o), .cpu_resume_o(resume),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Avalon-MM access: request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int   k;
    logic done;
    k    = 0;
    done = 1'h0;
    @(posedge clk_i);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    while (!done) begin
      @(posedge clk_i);
      k++;
      if (avs_waitrequest === 1'h0) begin
        done = 1'h1;
        q    = avs_readdata;
      end else if (k > 20) begin
        error_cnt++;
        give_verdict();
      end
    end
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask

  // Polls cpu_resume_o (which=1) or cpu_clk_en_o for a value, bounded
  task automatic wait_val(input logic which, input logic val, input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > lim) begin
        error_cnt++;
        give_verdict();
      end
    end while ((which ? resume : cpu_en) !== val);
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    {rst_i, pin_n, fuse, wdt_en, fail_safe_clock_monitor_en} = 5'h1F;
    {irq, wdt_to, avs_read, avs_write} = 4'h0;
    clk_src        = 3'h5;
    avs_address    = 4'h0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hF;
    error_cnt      = 0;
    checks_done    = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    fuse  <= 1'h0;
    step(3);
    chk(flags, 32'h7E);
    bus(0, ADDR_CLOCK_DIVIDER_REGISTER, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1, 4'hC, 32'hFFFFFFFF, rd);
    bus(0, 4'hC, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1, ADDR_CLOCK_DIVIDER_REGISTER, 32'hFFFFFFFF, rd);
    bus(0, ADDR_CLOCK_DIVIDER_REGISTER, 32'h0, rd);
    chk(rd, 32'hF800);
    avs_byteenable <= 4'h1;
    bus(1, ADDR_CLOCK_DIVIDER_REGISTER, 32'h0, rd);
    avs_byteenable <= 4'hF;
    bus(0, ADDR_CLOCK_DIVIDER_REGISTER, 32'h0, rd);
    chk(rd, 32'hF800);
    bus(1, ADDR_RCTRL, 32'hFFFFFFFF, rd);
    bus(0, ADDR_RCTRL, 32'h0, rd);
    chk(rd, 32'h1100);
    $display("test registers done");

    for (int r = 0; r < 8; r++) begin
      bus(1, ADDR_CLOCK_DIVIDER_REGISTER, 32'h800 | (r << 12), rd);
      step(4);
      n   = 0;
      lat = 0;
      repeat (256) begin
        @(posedge clk_i);
        #1;
        n   += (cpu_en === 1'h1);
        lat += (per_en === 1'h1);
      end
      chk(n, 256 >> r);
      chk(lat, 256);
    end
    for (int k = 0; k < 2; k++) begin
      bus(1, ADDR_CLOCK_DIVIDER_REGISTER, k ? 32'h1800 : 32'h9800, rd);
      @(posedge clk_i);
      irq <= 1'h1;
      step(3);
      @(posedge clk_i);
      irq <= 1'h0;
      bus(0, ADDR_CLOCK_DIVIDER_REGISTER, 32'h0, rd);
      chk(rd, k ? 32'h1800 : 32'h9000);
    end
    bus(1, ADDR_CLOCK_DIVIDER_REGISTER, 32'h0, rd);
    $display("test doze done");

    pmc_core_model_i.exec_power_save_instruction(1'h0);
    #1;
    chk({31'h0, wdt_clr}, 32'h1);
    step(4);
    chk(flags, 32'h3E);
    @(posedge clk_i);
    wdt_en <= 1'h0;
    step(3);
    chk(flags, 32'h3E);
    @(posedge clk_i);
    fail_safe_clock_monitor_en <= 1'h0;
    step(3);
    chk(flags, 32'h32);
    @(posedge clk_i);
    fail_safe_clock_monitor_en <= 1'h1;
    wdt_to  <= 1'h1;
    wait_val(0, 1'h1, 8);
    @(posedge clk_i);
    wdt_to <= 1'h0;
    wdt_en <= 1'h1;
    irq    <= 1'h1;
    pmc_core_model_i.exec_power_save_instruction(1'h0);
    wait_val(0, 1'h0, 4);
    wait_val(0, 1'h1, 8);
    @(posedge clk_i);
    irq <= 1'h0;
    $display("test idle done");

    for (int v = 0; v < 5; v++) begin
      @(posedge clk_i);
      fuse <= (v == 4);
      {retention_enable_bit, regulator_standby_bit} = mode_tbl[v];
      eff = retention_enable_bit & (v != 4);
      bus(1, ADDR_RCTRL, {19'h0, retention_enable_bit, 3'h0, regulator_standby_bit, 8'h0}, rd);
      step(4);
      pmc_core_model_i.exec_power_save_instruction(1'h1);
      #1;
      chk({31'h0, wdt_clr}, 32'h1);
      @(posedge clk_i);
      irq <= eff;
      step(120);
      chk(flags, {29'h1, !regulator_standby_bit, eff});
      bus(0, ADDR_STATUS, 32'h0, rd);
      chk(rd, {26'h0, eff, regulator_standby_bit, 4'h1});
      @(posedge clk_i);
      clk_src <= 3'h2;
      irq     <= 1'h0;
      step(2);
      chk({29'h0, src_o}, 32'h5);
      @(posedge clk_i);
      clk_src <= 3'h5;
      @(posedge clk_i);
      if (v == 0) wdt_to <= 1'h1;
      else irq <= 1'h1;
      lat = 1 + (regulator_standby_bit ? BANDGAP_CYC : 0) + (eff ? RECHARGE_CYC : 0);
      wait_val(1, 1'h1, 600);
      chk_rng(n, lat, lat + 8);
      chk({29'h0, src_o}, 32'h5);
      @(posedge clk_i);
      irq    <= 1'h0;
      wdt_to <= 1'h0;
    end
    $display("test sleep variants done");

    bus(1, ADDR_RCTRL, 32'h1100, rd);
    pmc_core_model_i.exec_power_save_instruction(1'h1);
    step(3);
    @(posedge clk_i);
    pin_n <= 1'h0;
    wait_val(1, 1'h1, 12);
    @(posedge clk_i);
    pin_n <= 1'h1;
    step(4);
    chk(flags, 32'h7E);
    $display("test reset pin done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== rtl/pmc_pkg.sv
/*
  Package for the power-mode controller: register map, field positions,
  reset values, timing figures and the carrier types shared by the design.
  Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package pmc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 50;
  localparam int RECHARGE_NS    = 10000;   // Extra wake time out of retention
  localparam int BANDGAP_NS     = 10000;   // Wake time saved by live band gaps
  localparam int RECHARGE_CYC   = (RECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BANDGAP_CYC    = (BANDGAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_POWER_RC_CLOCK_WAKE_NS   = 5000;    // Low-power RC start-up time
  localparam int LOW_POWER_RC_CLOCK_WAKE_CYC  = (LOW_POWER_RC_CLOCK_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_EDGES_ON  = 1;
  localparam int LOCK_EDGES_OFF = 2;
  localparam int REC_W          = 10;
  localparam int DOZE_W         = 3;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] ADDR_CLOCK_DIVIDER_REGISTER = 4'h0;
  localparam logic [3:0] ADDR_RCTRL  = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // clock_divider_register fields
  localparam int CD_ROI_BIT   = 15;
  localparam int CD_RATIO_LSB = 12;
  localparam int CD_DOZE_BIT  = 11;
  // reset_control_register fields
  localparam int RC_RETENTION_ENABLE_BIT_BIT = 12;
  localparam int RC_REGULATOR_STANDBY_BIT_BIT = 8;
  // Status fields
  localparam int ST_SLEEP_BIT = 0;
  localparam int ST_IDLE_BIT  = 1;
  localparam int ST_LOCK_BIT  = 2;
  localparam int ST_REC_BIT   = 3;
  localparam int ST_VAR_LSB   = 4;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic              interrupt_restore_full_speed;
    logic [DOZE_W-1:0] ratio;
    logic              doze_en;
  } pmc_clock_divider_register_t;

  typedef struct packed {
    logic retention_enable_bit;
    logic regulator_standby_bit;
  } pmc_rctrl_t;

  localparam pmc_clock_divider_register_t CLOCK_DIVIDER_REGISTER_RST = '{interrupt_restore_full_speed: 1'b0, ratio: 3'h0, doze_en: 1'b0};
  localparam pmc_rctrl_t  RCTRL_RST  = '{retention_enable_bit: 1'b0, regulator_standby_bit: 1'b0};

  typedef enum logic [2:0] {
    PMC_RUN, PMC_ENTER, PMC_SLEEP, PMC_IDLE, PMC_LOCK, PMC_RECOVER
  } pmc_state_t;

endpackage

// ===== rtl/pmc_top.sv
/*
  Power-mode controller: power-save instruction entry into Sleep or Idle,
  wake-up, four Sleep variants, retention lockout timed from the low-power
  RC clock, and Doze division of the CPU clock.
  Assumes the core, interrupt controller and watchdog share clk_i; the
  external reset pin, the low-power RC clock and the fuse are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Power-save instruction alone enters Sleep or Idle
// - Sleep stops all clocks but the low-power RC, and execution
// - Idle halts CPU, peripherals keep clock
// - Enabled interrupt, reset or watchdog wakes
// - Sleep entry shuts system clock source down
// - Fail-safe monitor off throughout Sleep
// - Low-power RC runs in Sleep with watchdog
// - Watchdog cleared before Sleep or Idle entry
// - System-clocked peripherals disabled during Sleep
// - Wake resumes on the clock source used before
// - Idle keeps RC clock for watchdog or monitor
// - Idle wake restarts CPU immediately
// - Interrupt during entry held, then wakes; after a lockout it stays masked until it drops
// - Retention regulator only in Sleep, fuse and enable
// - Retention exit adds recharge delay
// - Regulator standby clear keeps band gaps, faster wake
// - Lockout: only reset exits, interrupts masked
// - Lockout one RC period, else two plus start
// - Enable and standby decode four Sleep variants
// - Doze divides CPU clock, peripherals full speed
// - Doze enable bit and three-bit ratio, reset 1:1
// - Return-on-interrupt restores full speed
module pmc_top
  import pmc_pkg::*;
#(
  parameter int LOW_POWER_RC_CLOCK_WAKE = LOW_POWER_RC_CLOCK_WAKE_CYC
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Pins and fuse
  input  wire logic              external_reset_pin_n_i,
  input  wire logic              low_power_rc_clock_i,
  input  wire logic              retention_config_fuse_i,
  // Core, interrupt controller and watchdog
  input  wire logic              power_save_instruction_i,
  input  wire logic              power_save_sleep_i,
  input  wire logic              irq_pending_i,
  input  wire logic              watchdog_timer_en_i,
  input  wire logic              watchdog_timer_timeout_i,
  input  wire logic              fail_safe_clock_monitor_en_i,
  input  wire logic [2:0]        clk_src_i,
  // Clock and power controls
  output logic                   cpu_clk_en_o,
  output logic                   sys_clk_en_o,
  output logic                   periph_clk_en_o,
  output logic                   fail_safe_clock_monitor_active_o,
  output logic                   low_power_rc_clock_en_o,
  output logic                   watchdog_timer_clear_o,
  output logic                   retention_reg_en_o,
  output logic                   bandgap_en_o,
  output logic [2:0]             clk_src_o,
  output logic                   cpu_resume_o,
  // Avalon-MM slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       low_power_rc_clock_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q     <= 3'h5;
      sync2_q     <= 3'h5;
      low_power_rc_clock_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {retention_config_fuse_i, low_power_rc_clock_i, external_reset_pin_n_i};
      sync2_q     <= sync1_q;
      low_power_rc_clock_prev_q <= sync2_q[1];
    end
  end

  wire external_reset_pin_hit  = ~sync2_q[0];
  wire low_power_rc_clock_rise = sync2_q[1] & ~low_power_rc_clock_prev_q;
  wire fuse_prog = ~sync2_q[2];

  // ****************************************************************
  // Registers and bus slave
  // ****************************************************************
  pmc_clock_divider_register_t clock_divider_register_q;
  pmc_rctrl_t  rctrl_q;
  pmc_state_t  state_q;
  pmc_state_t  state_d;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        roi_fire;

  wire bus_req   = avs_read | avs_write;
  wire wr_commit = avs_write & ~wait_q;
  wire wr_clock_divider_register = wr_commit & (avs_address == ADDR_CLOCK_DIVIDER_REGISTER);
  wire wr_rctrl  = wr_commit & (avs_address == ADDR_RCTRL);
  wire [31:0] clock_divider_register_rd = {16'h0000, clock_divider_register_q.interrupt_restore_full_speed, clock_divider_register_q.ratio, clock_divider_register_q.doze_en, 11'h000};
  wire [31:0] rctrl_rd  = {19'h00000, rctrl_q.retention_enable_bit, 3'h0, rctrl_q.regulator_standby_bit, 8'h00};
  wire        ret_mode  = rctrl_q.retention_enable_bit & fuse_prog;
  wire [31:0] status_rd = {26'h0000000, ret_mode, rctrl_q.regulator_standby_bit,
                           state_q == PMC_RECOVER, state_q == PMC_LOCK,
                           state_q == PMC_IDLE, state_q == PMC_SLEEP};
  wire [31:0] rd_mux    = (avs_address == ADDR_CLOCK_DIVIDER_REGISTER) ? clock_divider_register_rd :
                          (avs_address == ADDR_RCTRL)  ? rctrl_rd  :
                          (avs_address == ADDR_STATUS) ? status_rd : 32'h00000000;

  // One wait cycle per access; write takes effect when waitrequest is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q  <= ~(bus_req & wait_q);
      rdata_q <= (avs_read & wait_q) ? rd_mux : rdata_q;
    end
  end

  wire         be_hi      = avs_byteenable[1];
  wire         be_lo      = avs_byteenable[0];
  pmc_clock_divider_register_t clock_divider_register_wr;
  assign clock_divider_register_wr.interrupt_restore_full_speed     = be_hi ? avs_writedata[CD_ROI_BIT] : clock_divider_register_q.interrupt_restore_full_speed;
  assign clock_divider_register_wr.ratio   = be_hi ? avs_writedata[CD_RATIO_LSB +: DOZE_W] : clock_divider_register_q.ratio;
  assign clock_divider_register_wr.doze_en = be_hi ? avs_writedata[CD_DOZE_BIT] : clock_divider_register_q.doze_en;

  pmc_clock_divider_register_t clock_divider_register_d;
  assign clock_divider_register_d = wr_clock_divider_register ? clock_divider_register_wr :
                    roi_fire  ? pmc_clock_divider_register_t'{interrupt_restore_full_speed: clock_divider_register_q.interrupt_restore_full_speed, ratio: clock_divider_register_q.ratio, doze_en: 1'b0} :
                    clock_divider_register_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_divider_register_q <= CLOCK_DIVIDER_REGISTER_RST;
      rctrl_q  <= RCTRL_RST;
    end else begin
      clock_divider_register_q <= clock_divider_register_d;
      if (wr_rctrl) begin
        rctrl_q.retention_enable_bit <= be_hi ? avs_writedata[RC_RETENTION_ENABLE_BIT_BIT] : rctrl_q.retention_enable_bit;
        rctrl_q.regulator_standby_bit <= be_hi ? avs_writedata[RC_REGULATOR_STANDBY_BIT_BIT] : rctrl_q.regulator_standby_bit;
      end
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;

  // ****************************************************************
  // Mode sequencer
  // ****************************************************************
  logic [REC_W-1:0] cnt_q;
  logic [REC_W-1:0] cnt_d;
  logic [1:0]       edges_q;
  logic [1:0]       edges_d;
  logic             irq_block_q;
  logic             low_power_rc_clock_on_q;

  wire sleepish  = (state_q == PMC_SLEEP) | (state_q == PMC_LOCK);
  wire irq_wake  = irq_pending_i & ~irq_block_q;
  wire any_wake  = irq_wake | watchdog_timer_timeout_i;
  wire enter_req = (state_q == PMC_RUN) & power_save_instruction_i;
  wire [REC_W-1:0] rec_load = REC_W'(1)
                            + (rctrl_q.regulator_standby_bit ? REC_W'(BANDGAP_CYC) : REC_W'(0))
                            + (ret_mode ? REC_W'(RECHARGE_CYC) : REC_W'(0));
  wire lock_done = (cnt_q == '0) & low_power_rc_clock_rise & (edges_q == 2'd1);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    edges_d = edges_q;
    case (state_q)
      PMC_RUN: begin
        if (enter_req) begin
          state_d = PMC_ENTER;
        end
      end
      PMC_ENTER: begin
        // Interrupts stay pending here and are seen in Idle or Sleep; a lockout masks them until they drop
        if (!power_save_sleep_i) begin
          state_d = PMC_IDLE;
        end else if (ret_mode) begin
          state_d = PMC_LOCK;
          cnt_d   = low_power_rc_clock_on_q ? REC_W'(0) : REC_W'(LOW_POWER_RC_CLOCK_WAKE);
          edges_d = low_power_rc_clock_on_q ? 2'(LOCK_EDGES_ON) : 2'(LOCK_EDGES_OFF);
        end else begin
          state_d = PMC_SLEEP;
        end
      end
      PMC_LOCK: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - REC_W'(1);
        end else if (low_power_rc_clock_rise) begin
          edges_d = edges_q - 2'd1;
        end
        if (lock_done) begin
          state_d = PMC_SLEEP;
        end
      end
      PMC_SLEEP: begin
        if (any_wake) begin
          state_d = PMC_RECOVER;
          cnt_d   = rec_load;
        end
      end
      PMC_IDLE: begin
        if (any_wake) begin
          state_d = PMC_RUN;
        end
      end
      PMC_RECOVER: begin
        cnt_d = cnt_q - REC_W'(1);
        if (cnt_q == REC_W'(1)) begin
          state_d = PMC_RUN;
        end
      end
      default: begin
        state_d = PMC_RUN;
      end
    endcase
    if (external_reset_pin_hit) begin
      state_d = PMC_RUN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= PMC_RUN;
      cnt_q       <= '0;
      edges_q     <= 2'd0;
      irq_block_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      edges_q     <= edges_d;
      irq_block_q <= (state_q == PMC_LOCK) ? irq_pending_i : (irq_block_q & irq_pending_i);
    end
  end

  // ****************************************************************
  // Doze divider
  // ****************************************************************
  logic [6:0] doze_cnt_q;
  wire  [6:0] doze_mask = 7'((8'h01 << clock_divider_register_q.ratio) - 8'h01);
  wire        doze_tick = (doze_cnt_q & doze_mask) == 7'h00;
  assign roi_fire = (state_q == PMC_RUN) & clock_divider_register_q.interrupt_restore_full_speed & clock_divider_register_q.doze_en & irq_pending_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      doze_cnt_q <= 7'h00;
    end else begin
      doze_cnt_q <= (state_q == PMC_RUN) ? doze_cnt_q + 7'h01 : 7'h00;
    end
  end

  // ****************************************************************
  // Clock and power outputs
  // ****************************************************************
  wire run_go    = (state_d == PMC_RUN) & (state_q == PMC_RUN);
  wire cpu_d     = run_go & (~clock_divider_register_d.doze_en | doze_tick);
  wire sleep_d   = (state_d == PMC_SLEEP) | (state_d == PMC_LOCK);
  wire idle_d    = state_d == PMC_IDLE;
  wire sys_d     = ~sleep_d;
  wire low_power_rc_clock_d    = (state_d == PMC_LOCK) | watchdog_timer_en_i
                 | (fail_safe_clock_monitor_en_i & ~sleep_d);
  wire resume_d  = (state_q != PMC_RUN) & (state_q != PMC_ENTER) & (state_d == PMC_RUN);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o                     <= 1'b0;
      sys_clk_en_o                     <= 1'b1;
      periph_clk_en_o                  <= 1'b1;
      fail_safe_clock_monitor_active_o <= 1'b0;
      low_power_rc_clock_en_o          <= 1'b0;
      watchdog_timer_clear_o           <= 1'b0;
      retention_reg_en_o               <= 1'b0;
      bandgap_en_o                     <= 1'b1;
      clk_src_o                        <= 3'h0;
      cpu_resume_o                     <= 1'b0;
      low_power_rc_clock_on_q                        <= 1'b0;
    end else begin
      cpu_clk_en_o                     <= cpu_d;
      sys_clk_en_o                     <= sys_d;
      periph_clk_en_o                  <= sys_d;
      fail_safe_clock_monitor_active_o <= fail_safe_clock_monitor_en_i & sys_d;
      low_power_rc_clock_en_o          <= low_power_rc_clock_d;
      low_power_rc_clock_on_q                        <= low_power_rc_clock_d;
      watchdog_timer_clear_o           <= enter_req & watchdog_timer_en_i;
      retention_reg_en_o               <= sleep_d & ret_mode;
      bandgap_en_o                     <= ~(sleep_d & rctrl_q.regulator_standby_bit);
      clk_src_o                        <= (state_q == PMC_RUN) ? clk_src_i : clk_src_o;
      cpu_resume_o                     <= resume_d & ~idle_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_sleep_clk_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == PMC_SLEEP && !any_wake && !external_reset_pin_hit) |=> !sys_clk_en_o && !cpu_clk_en_o)
    else $error("clocks running in sleep");

  a_idle_periph_on: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == PMC_IDLE && !any_wake && !external_reset_pin_hit) |=> periph_clk_en_o && !cpu_clk_en_o)
    else $error("idle clocking wrong");

  a_fail_safe_clock_monitor_sleep_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !sys_clk_en_o |-> !fail_safe_clock_monitor_active_o)
    else $error("monitor active in sleep");

  a_low_power_rc_clock_sleep_wdt: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_d && watchdog_timer_en_i) |=> low_power_rc_clock_en_o)
    else $error("rc clock stopped with watchdog on");

  a_entry_wdt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (enter_req && watchdog_timer_en_i) |=> watchdog_timer_clear_o ##1 !watchdog_timer_clear_o)
    else $error("watchdog not cleared on entry");

  a_entry_holds_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == PMC_ENTER && !external_reset_pin_hit) |=> state_q inside {PMC_SLEEP, PMC_IDLE, PMC_LOCK})
    else $error("entry did not complete");

  a_lock_masks_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == PMC_LOCK && !external_reset_pin_hit) |=> state_q inside {PMC_LOCK, PMC_SLEEP})
    else $error("lockout exited early");

  a_ret_reg_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
    retention_reg_en_o |-> $past(sleep_d) && $past(ret_mode))
    else $error("retention regulator outside sleep");

  a_idle_wake_now: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == PMC_IDLE && any_wake && !external_reset_pin_hit) |=> state_q == PMC_RUN ##1 cpu_clk_en_o || clock_divider_register_q.doze_en)
    else $error("idle wake slow");

  a_ret_recover_len: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == PMC_SLEEP && any_wake && ret_mode && !external_reset_pin_hit) |=> cnt_q > REC_W'(RECHARGE_CYC))
    else $error("retention recharge too short");

  a_roi_restore: assert property (@(posedge clk_i) disable iff (rst_i)
    (roi_fire && !wr_clock_divider_register) |=> !clock_divider_register_q.doze_en)
    else $error("interrupt did not restore speed");

  a_lock_rc_on: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == PMC_LOCK) |-> low_power_rc_clock_en_o)
    else $error("rc clock off during lockout");

  a_src_held_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q != PMC_RUN) |=> clk_src_o == $past(clk_src_o))
    else $error("clock source changed while stopped");

  a_sleep_sys_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == PMC_ENTER && power_save_sleep_i && !external_reset_pin_hit) |=> !sys_clk_en_o && !periph_clk_en_o)
    else $error("system clock left on at sleep entry");

  a_ret_off_run: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == PMC_RUN) |-> !retention_reg_en_o)
    else $error("retention regulator on while running");

endmodule

`default_nettype wire
